// [pkg/dcr_pkg.sv]
// package: register map, field layout and shared types of the datapath config bank
package dcr_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [4:0] ADDR_FILTER_FORMAT = 5'h01;
  localparam logic [4:0] ADDR_OUTPUT_DELAY = 5'h02;
  localparam logic [4:0] ADDR_FIFO_ALARM = 5'h03;
  localparam logic [4:0] ADDR_CURRENT_SCALE = 5'h04;
  localparam logic [4:0] ADDR_TEMPERATURE = 5'h05;
  localparam logic [4:0] ADDR_ALARM_STATUS = 5'h07;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_FILTER_FORMAT = 8'h11;
  localparam logic [7:0] RST_OUTPUT_DELAY = 8'h00;
  localparam logic [7:0] RST_FIFO_ALARM = 8'h10;
  localparam logic [7:0] RST_CURRENT_SCALE = 8'hFF;
  localparam logic [7:0] RST_ALARM_STATUS = 8'h00;
  // ---------------------------------------------------------------
  // writable bit masks (reserved bits stay zero)
  // ---------------------------------------------------------------
  localparam logic [7:0] MASK_FILTER_FORMAT = 8'h1D;
  localparam logic [7:0] MASK_OUTPUT_DELAY = 8'h0F;
  localparam logic [7:0] MASK_FIFO_ALARM = 8'h9F;
  localparam logic [7:0] MASK_CURRENT_SCALE = 8'hFF;
  localparam logic [7:0] MASK_ALARM_STATUS = 8'h6B;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BIT_INTERP = 4;
  localparam int BIT_SINC = 3;
  localparam int BIT_PATCHK = 2;
  localparam int BIT_TWOS = 0;
  localparam int BIT_AUTOCLR = 7;
  localparam int OFS_LSB = 2;
  localparam int BIT_TWO_APART = 1;
  localparam int BIT_ONE_APART = 0;
  localparam int SCALE_A_LSB = 4;
  localparam int SCALE_B_LSB = 0;
  localparam int ALM_ZERO = 6;
  localparam int ALM_COLL = 5;
  localparam int ALM_PATT = 3;
  localparam int ALM_TWO = 1;
  localparam int ALM_ONE = 0;
  // ---------------------------------------------------------------
  // counts
  // ---------------------------------------------------------------
  localparam int GOOD_RUN = 64;
  localparam logic [6:0] GOOD_RUN_CNT = 7'(GOOD_RUN);
  localparam int DELAY_TAPS = 16;
  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic interp_en;
    logic sinc_corr_en;
    logic pattern_check_en;
    logic twos_complement;
    logic [3:0] output_delay;
    logic alarm_auto_clear_enable;
    logic [2:0] fifo_sync_offset;
    logic two_apart_alarm_enable;
    logic one_apart_alarm_enable;
    logic [3:0] scale_a;
    logic [3:0] scale_b;
  } dcr_ctrl_t;

  typedef struct packed {
    logic write_ptr_zero;
    logic fifo_collision;
    logic pattern_mismatch;
    logic ptr_two_apart;
    logic ptr_one_apart;
  } dcr_alarm_t;
endpackage : dcr_pkg

// [design/dcr_regs.sv]
// design: datapath configuration and status register bank with delay line and alarm latch
// What this block does
// - interpolation enable, reset set, turns on 2x interpolation.
// - the sinc filter enable turns the correction filter on, usable only with interpolation.
// - the pattern checker runs only while its enable bit, reset clear, is set.
// - the format bit selects two's complement when set and offset binary when clear, reset set.
// - samples to both cores are delayed by 1 to 16 clock cycles, the delay field value plus one.
// - with auto-clear set, latched alarms clear after 64 consecutive good samples.
// - each read-pointer sync loads the 3-bit offset field, reset 100.
// - the two-apart proximity alarm is raised only while its enable is set.
// - the one-apart proximity alarm is raised only while its enable is set.
// - channel A and B current scale take 4-bit fields, 16 steps, reset all ones.
// - the temperature register is read-only and returns the sensor byte.
// - unused bits reset to zero and stay zero.
// - the alarm status register resets to zero and a host write clears the bits written as one.
module dcr_regs (
  input wire logic clk,
  input wire logic srst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  input wire logic [7:0] temp_code,
  input wire logic [31:0] sample_in,
  input wire logic sample_valid,
  input wire logic sample_good,
  input wire logic ptr_sync,
  input wire logic [2:0] ptr_distance,
  input wire dcr_pkg::dcr_alarm_t alarm_evt,
  output dcr_pkg::dcr_ctrl_t ctrl,
  output logic [31:0] sample_out,
  output logic [2:0] read_ptr_load,
  output logic read_ptr_load_en,
  output logic [7:0] alarm_status
);
  // ---------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------
  logic [7:0] filt_ff, dly_ff, fifo_ff, scale_ff, alarm_ff;
  logic [7:0] temp_s1_ff, temp_s2_ff;
  logic [6:0] good_cnt_ff;
  logic [31:0] taps_ff [dcr_pkg::DELAY_TAPS - 1];
  logic [7:0] rdata_ff;
  logic hit_ff;
  logic [2:0] ptr_load_ff;
  logic ptr_load_en_ff;
  dcr_pkg::dcr_ctrl_t ctrl_ff;
  logic [31:0] sample_out_ff;

  function automatic logic [7:0] masked(input logic [7:0] v, input logic [7:0] m);
    masked = v & m;
  endfunction : masked

  wire wr_filt = reg_wr && reg_addr == dcr_pkg::ADDR_FILTER_FORMAT;
  wire wr_dly = reg_wr && reg_addr == dcr_pkg::ADDR_OUTPUT_DELAY;
  wire wr_fifo = reg_wr && reg_addr == dcr_pkg::ADDR_FIFO_ALARM;
  wire wr_scale = reg_wr && reg_addr == dcr_pkg::ADDR_CURRENT_SCALE;
  wire wr_alarm = reg_wr && reg_addr == dcr_pkg::ADDR_ALARM_STATUS;

  // ---------------------------------------------------------------
  // alarm sources gated by their enables
  // ---------------------------------------------------------------
  wire two_apart = alarm_evt.ptr_two_apart && fifo_ff[dcr_pkg::BIT_TWO_APART];
  wire one_apart = alarm_evt.ptr_one_apart && fifo_ff[dcr_pkg::BIT_ONE_APART];
  wire patt = alarm_evt.pattern_mismatch && filt_ff[dcr_pkg::BIT_PATCHK];
  wire [7:0] alarm_set = {1'b0, alarm_evt.write_ptr_zero, alarm_evt.fifo_collision, 1'b0,
                          patt, 1'b0, two_apart, one_apart};
  wire auto_on = fifo_ff[dcr_pkg::BIT_AUTOCLR];
  wire run_done = auto_on && sample_valid && sample_good
                  && good_cnt_ff == dcr_pkg::GOOD_RUN_CNT - 7'h01;
  // write one clears; a new event in the same cycle wins
  wire [7:0] alarm_clr = (wr_alarm ? reg_wdata : 8'h00) | (run_done ? 8'hFF : 8'h00);
  wire [7:0] nxt_alarm = masked((alarm_ff & ~alarm_clr) | alarm_set,
                                dcr_pkg::MASK_ALARM_STATUS);
  wire [6:0] nxt_good_cnt = (!auto_on || (sample_valid && !sample_good) || run_done) ? 7'h00 :
                            (sample_valid ? good_cnt_ff + 7'h01 : good_cnt_ff);

  // ---------------------------------------------------------------
  // control decode
  // ---------------------------------------------------------------
  dcr_pkg::dcr_ctrl_t nxt_ctrl;
  always_comb begin
    nxt_ctrl.interp_en = filt_ff[dcr_pkg::BIT_INTERP];
    // sinc alone is meaningless without interpolation, so force it off
    nxt_ctrl.sinc_corr_en = filt_ff[dcr_pkg::BIT_SINC] && filt_ff[dcr_pkg::BIT_INTERP];
    nxt_ctrl.pattern_check_en = filt_ff[dcr_pkg::BIT_PATCHK];
    nxt_ctrl.twos_complement = filt_ff[dcr_pkg::BIT_TWOS];
    nxt_ctrl.output_delay = dly_ff[3:0];
    nxt_ctrl.alarm_auto_clear_enable = auto_on;
    nxt_ctrl.fifo_sync_offset = fifo_ff[dcr_pkg::OFS_LSB +: 3];
    nxt_ctrl.two_apart_alarm_enable = fifo_ff[dcr_pkg::BIT_TWO_APART];
    nxt_ctrl.one_apart_alarm_enable = fifo_ff[dcr_pkg::BIT_ONE_APART];
    nxt_ctrl.scale_a = scale_ff[dcr_pkg::SCALE_A_LSB +: 4];
    nxt_ctrl.scale_b = scale_ff[dcr_pkg::SCALE_B_LSB +: 4];
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  wire is_filt = reg_addr == dcr_pkg::ADDR_FILTER_FORMAT;
  wire is_dly = reg_addr == dcr_pkg::ADDR_OUTPUT_DELAY;
  wire is_fifo = reg_addr == dcr_pkg::ADDR_FIFO_ALARM;
  wire is_scale = reg_addr == dcr_pkg::ADDR_CURRENT_SCALE;
  wire is_temp = reg_addr == dcr_pkg::ADDR_TEMPERATURE;
  wire is_alarm = reg_addr == dcr_pkg::ADDR_ALARM_STATUS;
  wire nxt_hit = reg_rd && (is_filt || is_dly || is_fifo || is_scale || is_temp || is_alarm);
  wire [7:0] nxt_rdata = !reg_rd ? rdata_ff :
                         is_filt ? filt_ff :
                         is_dly ? dly_ff :
                         is_fifo ? fifo_ff :
                         is_scale ? scale_ff :
                         is_temp ? temp_s2_ff :
                         is_alarm ? alarm_ff : 8'h00;

  // ---------------------------------------------------------------
  // next register values
  // ---------------------------------------------------------------
  wire [7:0] nxt_filt = wr_filt ? masked(reg_wdata, dcr_pkg::MASK_FILTER_FORMAT)
                                : filt_ff;
  wire [7:0] nxt_dly = wr_dly ? masked(reg_wdata, dcr_pkg::MASK_OUTPUT_DELAY)
                              : dly_ff;
  wire [7:0] nxt_fifo = wr_fifo ? masked(reg_wdata, dcr_pkg::MASK_FIFO_ALARM)
                                : fifo_ff;
  wire [7:0] nxt_scale = wr_scale ? masked(reg_wdata, dcr_pkg::MASK_CURRENT_SCALE)
                                  : scale_ff;

  // ---------------------------------------------------------------
  // interpolation, filter and format register
  // ---------------------------------------------------------------
  // reserved bits are masked on the way in, so they never read back as one
  always_ff @(posedge clk) begin
    if (srst) begin
      filt_ff <= dcr_pkg::RST_FILTER_FORMAT;
    end else begin
      filt_ff <= nxt_filt;
    end
  end

  // ---------------------------------------------------------------
  // output delay register
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      dly_ff <= dcr_pkg::RST_OUTPUT_DELAY;
    end else begin
      dly_ff <= nxt_dly;
    end
  end

  // ---------------------------------------------------------------
  // fifo sync offset and alarm enable register
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      fifo_ff <= dcr_pkg::RST_FIFO_ALARM;
    end else begin
      fifo_ff <= nxt_fifo;
    end
  end

  // ---------------------------------------------------------------
  // current scale register
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      scale_ff <= dcr_pkg::RST_CURRENT_SCALE;
    end else begin
      scale_ff <= nxt_scale;
    end
  end

  // ---------------------------------------------------------------
  // alarm latch
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      alarm_ff <= dcr_pkg::RST_ALARM_STATUS;
    end else begin
      alarm_ff <= nxt_alarm;
    end
  end

  // ---------------------------------------------------------------
  // good-sample run counter
  // ---------------------------------------------------------------
  // the run restarts while auto-clear is off, so enabling it never clears at once
  always_ff @(posedge clk) begin
    if (srst) begin
      good_cnt_ff <= 7'h00;
    end else begin
      good_cnt_ff <= nxt_good_cnt;
    end
  end

  // ---------------------------------------------------------------
  // temperature synchroniser
  // ---------------------------------------------------------------
  // sensor byte comes from an analog block on its own timing; a byte caught
  // mid-change may read one step off, which a slow host read tolerates
  always_ff @(posedge clk) begin
    if (srst) begin
      temp_s1_ff <= 8'h00;
    end else begin
      temp_s1_ff <= temp_code;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      temp_s2_ff <= 8'h00;
    end else begin
      temp_s2_ff <= temp_s1_ff;
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ---------------------------------------------------------------
  // read hit
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      hit_ff <= 1'b0;
    end else begin
      hit_ff <= nxt_hit;
    end
  end

  // ---------------------------------------------------------------
  // decoded controls
  // ---------------------------------------------------------------
  // one cycle of lag on every control keeps each output a plain flop
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_ff <= '0;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // ---------------------------------------------------------------
  // read-pointer sync
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      ptr_load_ff <= 3'h0;
    end else begin
      ptr_load_ff <= fifo_ff[dcr_pkg::OFS_LSB +: 3];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ptr_load_en_ff <= 1'b0;
    end else begin
      ptr_load_en_ff <= ptr_sync;
    end
  end

  // ---------------------------------------------------------------
  // output delay line, 1..16 cycles
  // ---------------------------------------------------------------
  // delay 0 bypasses the taps and costs only the output flop; tap i holds
  // the sample from i+1 cycles back
  wire [3:0] out_delay = dly_ff[3:0];
  wire [3:0] tap_index = out_delay - 4'h1;
  wire [31:0] tap_sel = (out_delay == 4'h0) ? sample_in : taps_ff[tap_index];

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < dcr_pkg::DELAY_TAPS - 1; i++) begin
        taps_ff[i] <= 32'h0000_0000;
      end
    end else begin
      taps_ff[0] <= sample_in;
      for (int i = 1; i < dcr_pkg::DELAY_TAPS - 1; i++) begin
        taps_ff[i] <= taps_ff[i-1];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sample_out_ff <= 32'h0000_0000;
    end else begin
      sample_out_ff <= tap_sel;
    end
  end

  // ---------------------------------------------------------------
  // ports
  // ---------------------------------------------------------------
  assign reg_rdata = rdata_ff;
  assign reg_hit = hit_ff;
  assign ctrl = ctrl_ff;
  assign sample_out = sample_out_ff;
  assign read_ptr_load = ptr_load_ff;
  assign read_ptr_load_en = ptr_load_en_ff;
  assign alarm_status = alarm_ff;
  // ptr_distance is informative only; proximity events arrive already decoded
  wire unused_dist = ^ptr_distance;
endmodule : dcr_regs

// [testbench/dcr_regs_assertions.sv]
// checker: port-level properties of the datapath config bank
module dcr_regs_assertions (
  input wire logic clk,
  input wire logic srst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_hit,
  input wire logic ptr_sync,
  input wire dcr_pkg::dcr_alarm_t alarm_evt,
  input wire dcr_pkg::dcr_ctrl_t ctrl,
  input wire logic read_ptr_load_en,
  input wire logic [7:0] alarm_status
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_rd_unmapped;
    reg_rd && reg_addr == 5'h06;
  endsequence
  sequence s_clear_wr;
    reg_wr && reg_addr == 5'h07 && alarm_evt == 5'h00;
  endsequence
  a_hit_cause: assert property (reg_hit |-> $past(reg_rd)) else $error("hit without read");
  a_temp_hit: assert property (reg_rd && reg_addr == 5'h05 |=> reg_hit)
    else $error("temperature read missed");
  a_unmapped_miss: assert property (s_rd_unmapped |=> !reg_hit && reg_rdata == 8'h00)
    else $error("unmapped read answered");
  a_sinc_bypass: assert property (!ctrl.interp_en |-> !ctrl.sinc_corr_en)
    else $error("sinc on without interpolation");
  a_sync_pulse: assert property (read_ptr_load_en == $past(ptr_sync))
    else $error("pointer load not one cycle after sync");
  a_rsvd_zero: assert property ((alarm_status & 8'h94) == 8'h00)
    else $error("reserved alarm bit set");
  // ctrl lags its register by one cycle, so today's ctrl is the enable at the event
  a_one_gate: assert property ($rose(alarm_status[0]) |->
    $past(alarm_evt.ptr_one_apart) && ctrl.one_apart_alarm_enable)
    else $error("one-apart alarm");
  a_two_gate: assert property ($rose(alarm_status[1]) |->
    $past(alarm_evt.ptr_two_apart) && ctrl.two_apart_alarm_enable)
    else $error("two-apart alarm");
  a_patt_gate: assert property ($rose(alarm_status[3]) |->
    $past(alarm_evt.pattern_mismatch) && ctrl.pattern_check_en)
    else $error("pattern alarm");
  a_ctrl_reset: assert property ($fell(srst) |=> ctrl.interp_en && ctrl.twos_complement
    && ctrl.fifo_sync_offset == 3'h4 && ctrl.scale_a == 4'hF) else $error("ctrl reset decode");
  a_clear_bits: assert property (s_clear_wr |=> (alarm_status & $past(reg_wdata)) == 8'h00)
    else $error("alarm bits not cleared");
endmodule : dcr_regs_assertions

// [testbench/dcr_host_model.sv]
// host model: register master on the control side of the config bank
module dcr_host_model (
  input wire logic clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [4:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_hit
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 15'h0000;
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d; // stale data never looks valid
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [7:0] d, output logic h);
    if (a == dcr_pkg::ADDR_TEMPERATURE) repeat (10) @(posedge clk); // slow access
    @(posedge clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
    h = reg_hit;
  endtask : rd
endmodule : dcr_host_model

// [testbench/test_dcr_regs.sv]
// testbench: directed scenarios for the datapath config bank
module test_dcr_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, srst = 1'b1, reg_wr, reg_rd, reg_hit, read_ptr_load_en, h;
  logic sample_valid = 1'b0, sample_good = 1'b0, ptr_sync = 1'b0;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, alarm_status, d, temp_code = 8'hE7;
  logic [31:0] sample_in = 32'h0, sample_out;
  logic [2:0] read_ptr_load;
  dcr_pkg::dcr_alarm_t alarm_evt = 5'h00;
  dcr_pkg::dcr_ctrl_t ctrl;
  int err_count = 0, num_checks = 0;
  initial forever #50 clk = ~clk;
  always @(posedge clk) sample_in <= sample_in + 32'h1;
  dcr_host_model i_host (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_hit);
  dcr_regs i_dut (.clk, .srst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_hit,
    .temp_code, .sample_in, .sample_valid, .sample_good, .ptr_sync, .ptr_distance(3'h0),
    .alarm_evt, .ctrl, .sample_out, .read_ptr_load, .read_ptr_load_en, .alarm_status);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  task automatic t_reset;
    logic [4:0] a[5] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h07};
    logic [7:0] e[5] = '{8'h11, 8'h00, 8'h10, 8'hFF, 8'h00};
    foreach (a[i]) begin
      i_host.rd(a[i], d, h);
      chk({h, d}, {1'b1, e[i]});
    end
    $display("test reset values done");
  endtask : t_reset
  task automatic t_access;
    logic [7:0] m[4] = '{8'h1D, 8'h0F, 8'h9F, 8'hFF};
    for (int i = 0; i < 4; i++) begin
      i_host.wr(5'(i + 1), 8'hFF);
      i_host.rd(5'(i + 1), d, h);
      chk(d, m[i]);
    end
    chk({ctrl.interp_en, ctrl.sinc_corr_en, ctrl.pattern_check_en, ctrl.twos_complement}, 4'hF);
    i_host.wr(5'h05, 8'h00);
    i_host.rd(5'h05, d, h);
    chk({h, d}, {1'b1, temp_code});
    i_host.rd(5'h06, d, h);
    chk({h, d}, 9'h000);
    i_host.wr(5'h01, 8'h08);
    i_host.wr(5'h04, 8'h5A);
    repeat (2) @(posedge clk);
    #1;
    chk({ctrl.interp_en, ctrl.sinc_corr_en, ctrl.pattern_check_en, ctrl.twos_complement}, 0);
    chk({ctrl.scale_a, ctrl.scale_b}, 8'h5A);
    $display("test access done");
  endtask : t_access
  task automatic t_delay(input logic [3:0] dly);
    i_host.wr(5'h02, {4'h0, dly});
    repeat (20) @(posedge clk);
    #1;
    chk(sample_in - sample_out, 32'(dly) + 32'h1);
    $display("test delay %0d done", dly);
  endtask : t_delay
  task automatic t_sync;
    i_host.wr(5'h03, 8'h0C);
    @(posedge clk);
    ptr_sync <= 1'b1;
    @(posedge clk);
    ptr_sync <= 1'b0;
    #1;
    chk({read_ptr_load_en, read_ptr_load}, 4'hB);
    $display("test sync done");
  endtask : t_sync
  task automatic pulse(input dcr_pkg::dcr_alarm_t ev);
    @(posedge clk);
    alarm_evt <= ev;
    @(posedge clk);
    alarm_evt <= 5'h00;
    repeat (2) @(posedge clk);
    #1;
  endtask : pulse
  task automatic t_alarm;
    i_host.wr(5'h03, 8'h10);
    i_host.wr(5'h01, 8'h11);
    pulse(5'h07);
    chk(alarm_status, 8'h00);
    pulse(5'h18);
    chk(alarm_status, 8'h60);
    i_host.wr(5'h07, 8'h20);
    i_host.rd(5'h07, d, h);
    chk(d, 8'h40);
    i_host.wr(5'h03, 8'h93);
    i_host.wr(5'h01, 8'h15);
    pulse(5'h07);
    chk(alarm_status, 8'h4B);
    chk(ctrl, 22'h2FF35A);
    @(posedge clk);
    {sample_valid, sample_good} <= 2'b11;
    repeat (40) @(posedge clk);
    sample_good <= 1'b0; // a bad sample restarts the good run
    @(posedge clk);
    sample_good <= 1'b1;
    repeat (40) @(posedge clk);
    #1;
    chk(alarm_status, 8'h4B);
    repeat (23) @(posedge clk);
    #1;
    chk(alarm_status, 8'h4B);
    @(posedge clk);
    #1;
    chk(alarm_status, 8'h00);
    $display("test alarms done");
  endtask : t_alarm
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_access();
    t_delay(4'h0);
    t_delay(4'hF);
    t_sync();
    t_alarm();
    finish_test();
  end
  initial begin
    repeat (3000) @(posedge clk);
    err_count++;
    finish_test();
  end
endmodule : test_dcr_regs
bind dcr_regs dcr_regs_assertions i_chk (.clk, .srst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
  .reg_rdata, .reg_hit, .ptr_sync, .alarm_evt, .ctrl, .read_ptr_load_en, .alarm_status);
